// ===== verilog/hdec_pkg.sv
package hdec_pkg;

  // ----------------------------------------
  // Register map and field positions
  // ----------------------------------------
  localparam logic [7:0] ANALOG_DECODER_FORMAT_SELECT_OFS = 8'h3b;
  localparam int         FORMAT_THREE_PHASE_BIT           = 0;
  localparam int         HALL_CENTER_SAMPLE_BIT           = 4;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int MASK_STEP_NS    = 10;
  localparam int BLANK_STEP_NS   = 10;
  localparam int BLANK_MAX_NS    = 4095;
  localparam int FILTER_STEP_US  = 5;
  // Least time, so round up
  localparam int FILTER_STEP_CYC =
    (FILTER_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INTERP_MIN_RPM  = 60;

  // ----------------------------------------
  // Angles and arithmetic
  // ----------------------------------------
  localparam logic [15:0]        SECTOR_ANGLE  = 16'h2aab;
  localparam logic [15:0]        HALF_TURN     = 16'h8000;
  localparam logic signed [17:0] INV_SQRT3_Q16 = 18'sh093cd;
  localparam logic [4:0]         CORDIC_LAST   = 5'h0f;
  localparam logic [5:0]         DIV_LAST      = 6'h1f;

  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    PHI_SRC_HALL   = 2'h0,
    PHI_SRC_ANALOG = 2'h1,
    PHI_SRC_EXT    = 2'h2,
    PHI_SRC_QUAD   = 2'h3
  } hdec_phi_src_t;

  typedef enum logic [1:0] {
    AN_IDLE = 2'b00,
    AN_ROT  = 2'b01,
    AN_DIV  = 2'b11,
    AN_DONE = 2'b10
  } hdec_an_state_t;

endpackage

// ===== verilog/hdec_decoder.sv
`timescale 1ns/100ps
module hdec_decoder
  import hdec_pkg::*;
(
  // Clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_resetn,
  // Hall pins and power stage events
  input  wire logic                     i_sensor_line_one,
  input  wire logic                     i_sensor_line_two,
  input  wire logic                     i_sensor_line_three,
  input  wire logic                     i_pwm_switch_event,
  input  wire logic                     i_pwm_center,
  // Hall configuration
  input  wire logic [7:0]               i_hall_mode,
  input  wire logic [11:0]              i_hall_masking,
  input  wire logic [7:0]               i_sensor_stable_time,
  input  wire logic [11:0]              i_hall_blank,
  input  wire logic [5:0][15:0]         i_hall_state_angle,
  input  wire logic [15:0]              i_hall_phi_e_offset,
  input  wire logic                     i_hall_interp_en,
  input  wire logic signed [31:0]       i_velocity_rpm,
  // Analog encoder
  input  wire logic [2:0][15:0]         i_analog_track_raw,
  input  wire logic [2:0][15:0]         i_analog_track_offset,
  input  wire logic [2:0][15:0]         i_analog_track_gain,
  input  wire logic [15:0]              i_analog_index_raw,
  input  wire logic [31:0]              i_analog_decoder_format_select,
  input  wire logic [15:0]              i_analog_periods_per_rev,
  input  wire logic [7:0]               i_pole_pairs,
  // Selector, external position, multi-turn
  input  wire logic [1:0]               i_phi_e_select,
  input  wire logic [15:0]              i_ext_position,
  input  wire logic                     i_ext_position_wr,
  input  wire logic [31:0]              i_multi_turn_value,
  input  wire logic                     i_multi_turn_wr,
  // Quadrature encoder initialisation
  input  wire logic [15:0]              i_quad_phi_e_raw,
  input  wire logic                     i_quad_index,
  input  wire logic                     i_hall_ident_en,
  input  wire logic [15:0]              i_quad_offset,
  input  wire logic                     i_quad_offset_wr,
  // Hall results
  output logic [2:0]                    o_hall_state,
  output logic [15:0]                   o_hall_phi_e_raw,
  output logic [15:0]                   o_hall_phi_e,
  // Analog results
  output logic [2:0][15:0]              o_analog_track_value,
  output logic [15:0]                   o_analog_in_period_angle,
  output logic [15:0]                   o_analog_electrical_angle,
  output logic [15:0]                   o_analog_mechanical_angle,
  output logic [15:0]                   o_analog_index_raw,
  // Commutation and initialisation
  output logic [15:0]                   o_phi_e,
  output logic [31:0]                   o_multi_turn,
  output logic [15:0]                   o_quad_offset,
  output logic                          o_quad_offset_valid,
  output logic                          o_quad_ready
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0]       s1, s2, s3;
    logic [2:0]       hsync, hmask, hsamp, hcand, hfilt, hstate;
    logic [15:0]      mask_ns;
    logic [15:0]      filt_cnt;
    logic [12:0]      blank_ns;
    logic [23:0]      int_cnt, int_per;
    logic [24:0]      frac;
    logic [15:0]      interp, hall_raw, hall_phi;
    logic [2:0][15:0] trk;
    logic signed [19:0] cx, cy; // Signed so the shifts stay arithmetic
    logic [15:0]      cz;
    logic [4:0]       it;
    hdec_an_state_t   an;
    logic [15:0]      phi_a, period, phi_m, phi_ea;
    logic [16:0]      rem;
    logic [31:0]      quo;
    logic [5:0]       dcnt;
    logic [15:0]      aidx, ext_pos, phi_e, qoff;
    logic [31:0]      mturn;
    logic             qvalid, qready, armed, ident_q;
  } hdec_state_t;

  hdec_state_t st_q, st_d;

  // Arctangent of 2^-i, full turn is 65536
  function automatic logic [15:0] atan_lut(input logic [4:0] i);
    case (i)
      5'h00: atan_lut = 16'h2000;
      5'h01: atan_lut = 16'h12e4;
      5'h02: atan_lut = 16'h09fb;
      5'h03: atan_lut = 16'h0511;
      5'h04: atan_lut = 16'h028b;
      5'h05: atan_lut = 16'h0146;
      5'h06: atan_lut = 16'h00a3;
      5'h07: atan_lut = 16'h0051;
      5'h08: atan_lut = 16'h0029;
      5'h09: atan_lut = 16'h0014;
      5'h0a: atan_lut = 16'h000a;
      5'h0b: atan_lut = 16'h0005;
      5'h0c: atan_lut = 16'h0003;
      5'h0d: atan_lut = 16'h0001;
      5'h0e: atan_lut = 16'h0001;
      default: atan_lut = 16'h0000;
    endcase
  endfunction

  // Saturate a Q8.8 product back to 16 bits
  function automatic logic [15:0] sat16(input logic signed [32:0] p);
    logic signed [24:0] s;
    s = p[32:8];
    if (s > 25'sh0007fff)       sat16 = 16'h7fff;
    else if (s < -25'sh0008000) sat16 = 16'h8000;
    else                        sat16 = s[15:0];
  endfunction

  // ----------------------------------------
  // Helper terms
  // ----------------------------------------
  logic [15:0]        filt_lim;
  logic [31:0]        blank_prod;
  logic [31:0]        vel_abs;
  logic               interp_on;
  logic [2:0]         sel_idx;
  logic [15:0]        sel_angle;
  logic               hall_chg;
  logic signed [16:0] beta_d;
  logic signed [35:0] beta_p;

  assign filt_lim   = 16'(i_sensor_stable_time * FILTER_STEP_CYC);
  assign blank_prod = 32'(i_hall_blank * BLANK_STEP_NS);
  assign vel_abs    = i_velocity_rpm[31] ? 32'(-i_velocity_rpm)
                                         : 32'(i_velocity_rpm);
  // Low speed disables interpolation so a motor at rest sits still
  assign interp_on  = i_hall_interp_en &&
                      (vel_abs > 32'(INTERP_MIN_RPM));
  assign beta_d     = $signed({st_q.trk[1][15], st_q.trk[1]}) -
                      $signed({st_q.trk[2][15], st_q.trk[2]});
  assign beta_p     = beta_d * INV_SQRT3_Q16;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic signed [16:0] sum;
    logic signed [19:0] x0, y0;
    logic [16:0]        rn;
    st_d = st_q;
    sum  = '0;
    x0   = '0;
    y0   = '0;
    rn   = '0;
    hall_chg = 1'b0;

    // Three-stage pin chain, a change counts when the last two stages agree
    st_d.s1 = {i_sensor_line_three, i_sensor_line_two, i_sensor_line_one};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.hsync = st_q.s3;
    end

    // Freeze on switching events, counted in ns to keep 10 ns steps exact
    if (i_pwm_switch_event) begin
      st_d.mask_ns = 16'(i_hall_masking * MASK_STEP_NS);
    end else if (st_q.mask_ns > 16'(CLK_PERIOD_NS)) begin
      st_d.mask_ns = st_q.mask_ns - 16'(CLK_PERIOD_NS);
    end else begin
      st_d.mask_ns = '0;
    end
    if (!i_pwm_switch_event && st_q.mask_ns == '0) begin
      st_d.hmask = st_q.hsync;
    end

    // Centre sampling trades latency for PWM noise immunity
    if (!i_hall_mode[HALL_CENTER_SAMPLE_BIT] || i_pwm_center) begin
      st_d.hsamp = st_q.hmask;
    end

    // Stability filter
    if (st_q.hsamp != st_q.hcand) begin
      st_d.hcand    = st_q.hsamp;
      st_d.filt_cnt = '0;
    end else if (st_q.filt_cnt < filt_lim) begin
      st_d.filt_cnt = st_q.filt_cnt + 16'h0001;
    end else begin
      st_d.hfilt = st_q.hcand;
    end

    // Blanking after each accepted change; codes 0 and 7 never accepted
    if (st_q.blank_ns > 13'(CLK_PERIOD_NS)) begin
      st_d.blank_ns = st_q.blank_ns - 13'(CLK_PERIOD_NS);
    end else begin
      st_d.blank_ns = '0;
    end
    if (st_q.blank_ns == '0 && st_q.hfilt != st_q.hstate &&
        st_q.hfilt != 3'h0 && st_q.hfilt != 3'h7) begin
      hall_chg      = 1'b1;
      st_d.hstate   = st_q.hfilt;
      st_d.blank_ns = (blank_prod > 32'(BLANK_MAX_NS)) ?
                      13'(BLANK_MAX_NS) : 13'(blank_prod);
    end

    // Sector timing and interim interpolation
    if (hall_chg) begin
      st_d.int_per = st_q.int_cnt;
      st_d.int_cnt = '0;
      st_d.frac    = '0;
      st_d.interp  = '0;
    end else begin
      if (st_q.int_cnt != '1) begin
        st_d.int_cnt = st_q.int_cnt + 24'h000001;
      end
      st_d.frac = st_q.frac + {9'h000, SECTOR_ANGLE};
      if (st_q.frac >= {1'b0, st_q.int_per} && st_q.int_per != '0 &&
          st_q.interp < SECTOR_ANGLE - 16'h0001) begin
        st_d.frac   = st_q.frac - {1'b0, st_q.int_per};
        st_d.interp = st_q.interp + 16'h0001;
      end
    end
    // Angle lookup follows the state chosen this cycle
    sel_idx   = (st_d.hstate == 3'h0) ? 3'h0 : st_d.hstate - 3'h1;
    sel_angle = i_hall_state_angle[sel_idx];
    if (interp_on) begin
      st_d.hall_raw = i_velocity_rpm[31] ? sel_angle - st_d.interp
                                         : sel_angle + st_d.interp;
    end else begin
      st_d.hall_raw = sel_angle;
    end
    st_d.hall_phi = st_d.hall_raw + i_hall_phi_e_offset;

    // Offset correction and gain per channel
    for (int c = 0; c < 3; c++) begin
      sum = $signed({i_analog_track_raw[c][15], i_analog_track_raw[c]}) +
            $signed({i_analog_track_offset[c][15], i_analog_track_offset[c]});
      st_d.trk[c] = sat16(sum * $signed(i_analog_track_gain[c]));
    end
    st_d.aidx = i_analog_index_raw;

    // Serial arctangent then period count and mechanical angle
    unique case (st_q.an)
      AN_IDLE: begin
        if (i_analog_decoder_format_select[FORMAT_THREE_PHASE_BIT]) begin
          x0 = 20'($signed(st_q.trk[0]));
          y0 = 20'($signed(beta_p[31:16]));
        end else begin
          x0 = 20'($signed(st_q.trk[1]));
          y0 = 20'($signed(st_q.trk[0]));
        end
        st_d.cx = x0[19] ? -x0 : x0;
        st_d.cy = x0[19] ? -y0 : y0;
        st_d.cz = x0[19] ? HALF_TURN : 16'h0000;
        st_d.it = '0;
        st_d.an = AN_ROT;
      end
      AN_ROT: begin
        if (st_q.cy[19]) begin
          st_d.cx = st_q.cx - ($signed(st_q.cy) >>> st_q.it);
          st_d.cy = st_q.cy + ($signed(st_q.cx) >>> st_q.it);
          st_d.cz = st_q.cz - atan_lut(st_q.it);
        end else begin
          st_d.cx = st_q.cx + ($signed(st_q.cy) >>> st_q.it);
          st_d.cy = st_q.cy - ($signed(st_q.cx) >>> st_q.it);
          st_d.cz = st_q.cz + atan_lut(st_q.it);
        end
        st_d.it = st_q.it + 5'h01;
        if (st_q.it == CORDIC_LAST) begin
          st_d.phi_a = st_d.cz;
          if (st_q.phi_a[15:14] == 2'b11 && st_d.cz[15:14] == 2'b00) begin
            st_d.period = (st_q.period + 16'h0001 >= i_analog_periods_per_rev)
                          ? 16'h0000 : st_q.period + 16'h0001;
          end else if (st_q.phi_a[15:14] == 2'b00 &&
                       st_d.cz[15:14] == 2'b11) begin
            st_d.period = (st_q.period == 16'h0000)
                          ? i_analog_periods_per_rev - 16'h0001
                          : st_q.period - 16'h0001;
          end
          st_d.quo  = {st_d.period, st_d.cz};
          st_d.rem  = '0;
          st_d.dcnt = '0;
          st_d.an   = AN_DIV;
        end
      end
      AN_DIV: begin
        rn = {st_q.rem[15:0], st_q.quo[31]};
        if (rn >= {1'b0, i_analog_periods_per_rev}) begin
          st_d.rem = rn - {1'b0, i_analog_periods_per_rev};
          st_d.quo = {st_q.quo[30:0], 1'b1};
        end else begin
          st_d.rem = rn;
          st_d.quo = {st_q.quo[30:0], 1'b0};
        end
        st_d.dcnt = st_q.dcnt + 6'h01;
        if (st_q.dcnt == DIV_LAST) begin
          st_d.an = AN_DONE;
        end
      end
      AN_DONE: begin
        st_d.phi_m  = st_q.quo[15:0];
        st_d.phi_ea = 16'(st_q.quo[15:0] * i_pole_pairs);
        st_d.an     = AN_IDLE;
      end
    endcase

    // External position written by the host
    if (i_ext_position_wr) begin
      st_d.ext_pos = i_ext_position;
    end

    // Offset identification, armed on each rising enable
    st_d.ident_q = i_hall_ident_en;
    if (!i_hall_ident_en) begin
      st_d.armed = 1'b0;
    end else if (!st_q.ident_q) begin
      st_d.armed = 1'b1;
    end
    if (i_quad_offset_wr) begin
      st_d.qoff   = i_quad_offset;
      st_d.qvalid = 1'b1;
    end else if (st_q.armed && i_hall_ident_en && hall_chg) begin
      st_d.qoff   = st_d.hall_phi - i_quad_phi_e_raw;
      st_d.qvalid = 1'b1;
      st_d.armed  = 1'b0;
    end
    if (i_quad_index && st_q.qvalid) begin
      st_d.qready = 1'b1;
    end

    // Commutation source; secondary encoder deliberately absent
    unique case (hdec_phi_src_t'(i_phi_e_select))
      PHI_SRC_HALL:   st_d.phi_e = st_q.hall_phi;
      PHI_SRC_ANALOG: st_d.phi_e = st_q.phi_ea;
      PHI_SRC_EXT:    st_d.phi_e = st_q.ext_pos;
      PHI_SRC_QUAD: begin
        if (st_q.qready) begin
          st_d.phi_e = i_quad_phi_e_raw + st_q.qoff;
        end
      end
    endcase

    // Multi-turn follows angle steps, wrap taken as signed delta
    if (i_multi_turn_wr) begin
      st_d.mturn = i_multi_turn_value;
    end else begin
      st_d.mturn = st_q.mturn +
                   32'($signed(st_d.phi_e - st_q.phi_e));
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state
  assign o_hall_state              = st_q.hstate;
  assign o_hall_phi_e_raw          = st_q.hall_raw;
  assign o_hall_phi_e              = st_q.hall_phi;
  assign o_analog_track_value      = st_q.trk;
  assign o_analog_in_period_angle  = st_q.phi_a;
  assign o_analog_electrical_angle = st_q.phi_ea;
  assign o_analog_mechanical_angle = st_q.phi_m;
  assign o_analog_index_raw        = st_q.aidx;
  assign o_phi_e                   = st_q.phi_e;
  assign o_multi_turn              = st_q.mturn;
  assign o_quad_offset             = st_q.qoff;
  assign o_quad_offset_valid       = st_q.qvalid;
  assign o_quad_ready              = st_q.qready;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [15:0] sel_angle_q;
  always_ff @(posedge i_core_clk) begin
    sel_angle_q <= sel_angle;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  property p_hall_offset;
    $past(i_resetn) |->
      o_hall_phi_e == 16'(o_hall_phi_e_raw + $past(i_hall_phi_e_offset));
  endproperty
  a_hall_offset: assert property (p_hall_offset)
    else $error("hall angle offset wrong");

  property p_plain_angle;
    !interp_on |=> o_hall_phi_e_raw == sel_angle_q;
  endproperty
  a_plain_angle: assert property (p_plain_angle)
    else $error("plain hall angle expected at low speed");

  property p_sector_bound;
    interp_on |=> (16'(o_hall_phi_e_raw - sel_angle_q) < SECTOR_ANGLE) ||
                  (16'(sel_angle_q - o_hall_phi_e_raw) < SECTOR_ANGLE);
  endproperty
  a_sector_bound: assert property (p_sector_bound)
    else $error("interpolated angle left its sector");

  property p_mask_hold;
    i_pwm_switch_event && i_hall_masking >= 12'd5 |=> $stable(st_q.hmask) [*2];
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("hall input not frozen after switching");

  property p_filter;
    $changed(st_q.hfilt) |-> $past(st_q.filt_cnt) >= $past(filt_lim);
  endproperty
  a_filter: assert property (p_filter)
    else $error("filter passed an unstable level");

  property p_center;
    i_hall_mode[HALL_CENTER_SAMPLE_BIT] && !i_pwm_center |=> $stable(st_q.hsamp);
  endproperty
  a_center: assert property (p_center)
    else $error("hall sampled away from pwm centre");

  property p_blank;
    $changed(o_hall_state) && $past(i_hall_blank) >= 12'd5 |=>
      $stable(o_hall_state) [*2];
  endproperty
  a_blank: assert property (p_blank)
    else $error("hall change inside blanking time");

  sequence s_ext_write;
    i_ext_position_wr && i_phi_e_select == PHI_SRC_EXT;
  endsequence
  sequence s_ext_hold;
    !i_ext_position_wr && i_phi_e_select == PHI_SRC_EXT;
  endsequence
  property p_ext_select;
    s_ext_write ##1 s_ext_hold |=> o_phi_e == $past(i_ext_position, 2);
  endproperty
  a_ext_select: assert property (p_ext_select)
    else $error("external position not selected");

  property p_multi_turn;
    i_multi_turn_wr |=> o_multi_turn == $past(i_multi_turn_value);
  endproperty
  a_multi_turn: assert property (p_multi_turn)
    else $error("multi-turn overwrite lost");

  property p_ident;
    $past(st_q.armed && i_hall_ident_en && !i_quad_offset_wr) &&
      $changed(o_hall_state) |->
      o_quad_offset_valid && o_quad_offset == 16'(o_hall_phi_e - $past(i_quad_phi_e_raw));
  endproperty
  a_ident: assert property (p_ident)
    else $error("offset not identified at hall change");

  property p_index_ready;
    i_quad_index && o_quad_offset_valid |=> o_quad_ready;
  endproperty
  a_index_ready: assert property (p_index_ready)
    else $error("quadrature not initialised after index");

endmodule

// ===== dv/hdec_sensor_model.sv
`timescale 1ns/100ps
// ------------------------------------
// Hall pins and analog tracks of the rotor
// ------------------------------------
module hdec_sensor_model (
  // Commands from the bench
  input  wire logic        i_three_phase,
  input  wire logic [2:0]  i_code,
  // Sensor outputs
  output logic             o_line_one,
  output logic             o_line_two,
  output logic             o_line_three,
  output logic [2:0][15:0] o_track_raw
);
  // Pin edges land between clock edges, as a real rotor gives them
  assign #7 {o_line_three, o_line_two, o_line_one} = i_code;
  // Rotor parked at 90 deg; three phase sits at 0, +A, -A
  assign o_track_raw = i_three_phase ? {16'hc000, 16'h4000, 16'h0000}
                                     : {16'h0000, 16'h0000, 16'h4000};
endmodule

// ===== dv/hall_and_analog_angle_decoder_test.sv
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("FAIL %0t mismatch %h vs %h", $time, (a), (e)); end end
module hall_and_analog_angle_decoder_test;
  import hdec_pkg::*;
  // ------------------------------------
  // Stimulus and results
  // ------------------------------------
  logic i_core_clk, i_resetn, i_sensor_line_one, i_sensor_line_two, i_sensor_line_three;
  logic i_pwm_switch_event, i_pwm_center, i_hall_interp_en, i_ext_position_wr;
  logic i_multi_turn_wr, i_quad_index, i_hall_ident_en, i_quad_offset_wr;
  logic o_quad_offset_valid, o_quad_ready;
  logic [7:0] i_hall_mode, i_sensor_stable_time, i_pole_pairs;
  logic [11:0] i_hall_masking, i_hall_blank;
  logic [15:0] i_hall_phi_e_offset, i_analog_index_raw, i_analog_periods_per_rev;
  logic [15:0] i_ext_position, i_quad_phi_e_raw, i_quad_offset, o_hall_phi_e_raw;
  logic [15:0] o_hall_phi_e, o_phi_e, o_quad_offset, o_analog_in_period_angle;
  logic [15:0] o_analog_electrical_angle, o_analog_mechanical_angle, o_analog_index_raw;
  logic [5:0][15:0] i_hall_state_angle;
  logic [2:0][15:0] i_analog_track_raw, i_analog_track_offset, i_analog_track_gain;
  logic [2:0][15:0] o_analog_track_value;
  logic signed [31:0] i_velocity_rpm;
  logic [31:0] i_analog_decoder_format_select, i_multi_turn_value, o_multi_turn;
  logic [1:0] i_phi_e_select;
  logic [2:0] o_hall_state, code;
  logic [15:0] exp_ang;
  int bad_count, total_checks;
  // Rows: code on the pins beside the state it should give; 7 is refused
  logic [2:0] row_code [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [2:0] row_exp  [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6};

  hdec_decoder DUT (.i_core_clk, .i_resetn, .i_sensor_line_one, .i_sensor_line_two,
    .i_sensor_line_three, .i_pwm_switch_event, .i_pwm_center, .i_hall_mode, .i_hall_masking,
    .i_sensor_stable_time, .i_hall_blank, .i_hall_state_angle, .i_hall_phi_e_offset,
    .i_hall_interp_en, .i_velocity_rpm, .i_analog_track_raw, .i_analog_track_offset,
    .i_analog_track_gain, .i_analog_index_raw, .i_analog_decoder_format_select,
    .i_analog_periods_per_rev, .i_pole_pairs, .i_phi_e_select, .i_ext_position,
    .i_ext_position_wr, .i_multi_turn_value, .i_multi_turn_wr, .i_quad_phi_e_raw,
    .i_quad_index, .i_hall_ident_en, .i_quad_offset, .i_quad_offset_wr, .o_hall_state,
    .o_hall_phi_e_raw, .o_hall_phi_e, .o_analog_track_value, .o_analog_in_period_angle,
    .o_analog_electrical_angle, .o_analog_mechanical_angle, .o_analog_index_raw, .o_phi_e,
    .o_multi_turn, .o_quad_offset, .o_quad_offset_valid, .o_quad_ready);
  hdec_sensor_model u_rotor (.i_three_phase(i_analog_decoder_format_select[0]),
    .i_code(code), .o_line_one(i_sensor_line_one), .o_line_two(i_sensor_line_two),
    .o_line_three(i_sensor_line_three), .o_track_raw(i_analog_track_raw));

  // ------------------------------------
  // Helpers
  // ------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #2;
  endtask
  // Bounded wait, so a stuck decoder shows as a mismatch, not a hang
  task automatic wait_hall(input logic [2:0] c, input int lim);
    for (int n = 0; n < lim && o_hall_state !== c; n++) cyc(1);
    `CHK(o_hall_state, c)
  endtask
  // Arctangent result is approximate, so allow a small window
  task automatic near(input logic [15:0] v, input logic [15:0] e);
    logic signed [15:0] d;
    d = v - e;
    `CHK(d > -16'sd128 && d < 16'sd128, 1'b1)
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    i_core_clk = 0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  // Whole run is about a thousand cycles, well inside the 12000-cycle limit
  initial begin
    #300us;
    bad_count++;
    close_out;
  end

  // ------------------------------------
  // Main sequence
  // ------------------------------------
  initial begin
    {i_resetn, i_pwm_switch_event, i_pwm_center, i_hall_interp_en, i_ext_position_wr} = '0;
    {i_multi_turn_wr, i_quad_index, i_hall_ident_en, i_quad_offset_wr, code} = '0;
    {i_hall_mode, i_sensor_stable_time, i_hall_masking, i_hall_blank, i_phi_e_select} = '0;
    {i_velocity_rpm, i_ext_position, i_multi_turn_value, i_quad_offset} = '0;
    for (int k = 0; k < 6; k++) i_hall_state_angle[k] = 16'h1000 * (k + 1);
    i_hall_phi_e_offset = 16'h0100;
    i_quad_phi_e_raw = 16'h0300;
    i_analog_track_offset = {16'h0010, 16'h0000, 16'h0000};
    i_analog_track_gain = {16'h0200, 16'h0100, 16'h0100};
    i_analog_index_raw = 16'h0abc;
    i_analog_decoder_format_select = '0;
    i_analog_periods_per_rev = 16'h0001;
    i_pole_pairs = 8'h02;
    cyc(16);
    i_resetn = 1;
    cyc(1);
    `CHK(o_hall_state, 3'h0)
    `CHK(o_quad_ready, 1'b0)
    i_hall_ident_en = 1;
    cyc(2);
    for (int r = 0; r < 7; r++) begin
      code = row_code[r];
      cyc(20);
      wait_hall(row_exp[r], 40);
      cyc(2);
      exp_ang = i_hall_state_angle[row_exp[r] - 1];
      `CHK(o_hall_phi_e_raw, exp_ang)
      `CHK(o_hall_phi_e, 16'(exp_ang + 16'h0100))
      `CHK(o_phi_e, 16'(exp_ang + 16'h0100))
    end
    // Offset taken at the first change after arming: 1100 - 0300
    `CHK(o_quad_offset_valid, 1'b1)
    `CHK(o_quad_offset, 16'h0e00)
    i_quad_index = 1;
    cyc(1);
    i_quad_index = 0;
    cyc(1);
    `CHK(o_quad_ready, 1'b1)
    i_phi_e_select = 2'h3;
    cyc(3);
    `CHK(o_phi_e, 16'h1100)
    // Stored offset reused, then identification re-armed
    i_quad_offset = 16'h0123;
    i_quad_offset_wr = 1;
    cyc(1);
    i_quad_offset_wr = 0;
    cyc(2);
    `CHK(o_quad_offset, 16'h0123)
    `CHK(o_phi_e, 16'h0423)
    i_hall_ident_en = 0;
    cyc(1);
    i_hall_ident_en = 1;
    cyc(2);
    // Masking: 200 x 10 ns is 80 cycles of freeze
    i_hall_masking = 12'h0c8;
    i_pwm_switch_event = 1;
    code = 3'h1;
    cyc(1);
    i_pwm_switch_event = 0;
    cyc(40);
    `CHK(o_hall_state, 3'h6)
    wait_hall(3'h1, 80);
    `CHK(o_quad_offset, 16'h0e00)
    i_hall_masking = '0;
    // Filter: one step is 200 cycles
    i_sensor_stable_time = 8'h01;
    code = 3'h2;
    cyc(150);
    `CHK(o_hall_state, 3'h1)
    wait_hall(3'h2, 100);
    i_sensor_stable_time = '0;
    // Centre sampling holds until the centre pulse
    i_hall_mode = 8'h10;
    code = 3'h3;
    cyc(50);
    `CHK(o_hall_state, 3'h2)
    i_pwm_center = 1;
    cyc(1);
    i_pwm_center = 0;
    wait_hall(3'h3, 20);
    i_hall_mode = '0;
    // Blanking: 1000 ns is 40 cycles, a quick second change waits it out
    i_hall_blank = 12'h064;
    code = 3'h4;
    wait_hall(3'h4, 40);
    code = 3'h5;
    cyc(15);
    `CHK(o_hall_state, 3'h4)
    wait_hall(3'h5, 60);
    // External position then multi-turn overwrite with a still angle
    i_ext_position = 16'h5a5a;
    i_ext_position_wr = 1;
    i_phi_e_select = 2'h2;
    cyc(1);
    i_ext_position_wr = 0;
    cyc(2);
    `CHK(o_phi_e, 16'h5a5a)
    i_multi_turn_value = 32'h0001_2345;
    i_multi_turn_wr = 1;
    cyc(1);
    i_multi_turn_wr = 0;
    cyc(2);
    `CHK(o_multi_turn, 32'h0001_2345)
    // Interpolation above 60 rpm, plain angle again at 60 rpm
    i_hall_interp_en = 1;
    i_velocity_rpm = 32'sd100;
    cyc(2);
    `CHK(o_hall_phi_e_raw > 16'h5000 && o_hall_phi_e_raw < 16'h7aab, 1'b1)
    i_velocity_rpm = 32'sd60;
    cyc(2);
    `CHK(o_hall_phi_e_raw, 16'h5000)
    // Analog: both formats at 90 deg, ppr 1, two pole pairs
    for (int f = 0; f < 2; f++) begin
      i_analog_decoder_format_select = 32'(f);
      cyc(150);
      `CHK(o_analog_track_value[2], (f == 0) ? 16'h0020 : 16'h8020)
      near(o_analog_in_period_angle, 16'h4000);
      near(o_analog_mechanical_angle, 16'h4000);
      near(o_analog_electrical_angle, 16'h8000);
    end
    `CHK(o_analog_index_raw, 16'h0abc)
    i_phi_e_select = 2'h1;
    cyc(3);
    near(o_phi_e, 16'h8000);
    close_out;
  end
endmodule
